/* src/sfre_cfg.svh */
`ifndef SFRE_CFG_SVH
`define SFRE_CFG_SVH
// read opcodes
`define SFRE_OP_READ 8'h03
`define SFRE_OP_FAST 8'h0B
`define SFRE_OP_DOUT 8'h3B
`define SFRE_OP_DIO 8'hBB
`define SFRE_OP_QOUT 8'h6B
`define SFRE_OP_QIO 8'hEB
`define SFRE_OP_QDDR 8'hED
// frame field lengths in bits
`define SFRE_OPC_BITS 4'd8
`define SFRE_ADDR_BITS 6'd32
// dummy clocks
`define SFRE_DUMMY_NONE 4'd0
`define SFRE_DUMMY_DEF 4'd10
`define SFRE_DC_SDR_00 4'd10
`define SFRE_DC_SDR_01 4'd6
`define SFRE_DC_SDR_10 4'd8
`define SFRE_DC_SDR_11 4'd10
`define SFRE_DC_DDR_00 4'd6
`define SFRE_DC_DDR_01 4'd4
`define SFRE_DC_DDR_10 4'd5
`define SFRE_DC_DDR_11 4'd7
// enhance indicator and preamble
`define SFRE_IND_CLKS 4'd2
`define SFRE_PREAMBLE 8'h34
`endif

/* src/sfre_pkg.sv */
`default_nettype none
package sfre_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} sfre_phase_t;
  typedef enum logic [2:0] {RD_PLAIN, RD_FAST, RD_DOUT, RD_DIO, RD_QOUT, RD_QIO, RD_QDDR} sfre_rdcmd_t;
  typedef struct packed {
    logic dummy_sel_hi;
    logic dummy_sel_lo;
    logic preamble_enable;
    logic four_line_command_mode;
  } sfre_cfg_t;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } sfre_pins_t;
endpackage
`default_nettype wire

/* src/sfre_serial_flash_read_engine.sv */
`include "sfre_cfg.svh"
`default_nettype none

// ************************************************************
// fifo between array fetch and serial shifter
// ************************************************************
module sfre_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import sfre_pkg::*;
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0] wp;
    logic [PW:0] rp;
  } sfre_fifo_st_t;
  sfre_fifo_st_t s_r, s_nxt;

  assign in_ready = (s_r.wp[PW-1:0] != s_r.rp[PW-1:0]) || (s_r.wp[PW] == s_r.rp[PW]);
  assign out_valid = s_r.wp != s_r.rp;
  assign out_data = s_r.mem[s_r.rp[PW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (flush) begin
      s_nxt.wp = s_r.rp;
    end else begin
      if (in_valid && in_ready) begin
        s_nxt.mem[s_r.wp[PW-1:0]] = in_data;
        s_nxt.wp = s_r.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
        s_nxt.rp = s_r.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // sfre_fifo

// ************************************************************
// read engine
// ************************************************************
module sfre_serial_flash_read_engine #(
  parameter int ARRAY_AW = 26,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic [3:0] io_line_in,
  output sfre_pkg::sfre_pins_t io_line_pins,
  input wire sfre_pkg::sfre_cfg_t cfg,
  input wire logic write_busy,
  output logic arr_rd_en,
  output logic [ARRAY_AW-1:0] arr_addr,
  input wire logic [7:0] arr_data,
  output logic enhance_mode,
  output logic frame_active
);
  import sfre_pkg::*;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic cs_s1;
    logic cs_s2;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    sfre_phase_t phase;
    sfre_rdcmd_t cmd;
    logic [7:0] opc;
    logic [5:0] cnt;
    logic [31:0] addr;
    logic [3:0] dcnt;
    logic [3:0] dnum;
    logic [7:0] ind;
    logic enh;
    sfre_rdcmd_t enh_cmd;
    logic [7:0] sh;
    logic [3:0] bleft;
    sfre_pins_t pins;
    logic [ARRAY_AW-1:0] faddr;
    logic fetch_on;
    logic pend;
  } sfre_st_t;
  sfre_st_t s_r, s_nxt;

  logic rise, fall, drive_ev, pop;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out;
  logic [7:0] byte_now;
  logic [3:0] w;
  logic [5:0] cnt_new;
  logic [7:0] pre_w;

  assign rise = s_r.sclk_s2 && !s_r.sclk_s3;
  assign fall = !s_r.sclk_s2 && s_r.sclk_s3;
  // ddr data changes on both edges, sdr on the fall only
  assign drive_ev = fall || (rise && s_r.cmd == RD_QDDR);
  assign pop = (s_r.phase == PH_DATA) && drive_ev && (s_r.bleft == 4'd0) && !s_r.cs_s2;
  assign arr_rd_en = s_r.fetch_on && !s_r.pend && fifo_in_ready;
  assign arr_addr = s_r.faddr;
  assign io_line_pins = s_r.pins;
  assign enhance_mode = s_r.enh;
  assign frame_active = s_r.phase != PH_IDLE;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [3:0] addr_width(input sfre_rdcmd_t c);
    unique case (c)
      RD_PLAIN, RD_FAST, RD_DOUT, RD_QOUT: addr_width = 4'd1;
      RD_DIO: addr_width = 4'd2;
      RD_QIO, RD_QDDR: addr_width = 4'd4;
    endcase
  endfunction

  function automatic logic [3:0] data_width(input sfre_rdcmd_t c);
    unique case (c)
      RD_PLAIN, RD_FAST: data_width = 4'd1;
      RD_DOUT, RD_DIO: data_width = 4'd2;
      RD_QOUT, RD_QIO, RD_QDDR: data_width = 4'd4;
    endcase
  endfunction

  function automatic logic [3:0] dummy_clks(input sfre_rdcmd_t c, input logic hi, input logic lo);
    unique case (c)
      RD_PLAIN: dummy_clks = `SFRE_DUMMY_NONE;
      RD_FAST, RD_DOUT, RD_DIO: dummy_clks = `SFRE_DUMMY_DEF;
      RD_QOUT, RD_QIO: begin
        unique case ({hi, lo})
          2'b00: dummy_clks = `SFRE_DC_SDR_00;
          2'b01: dummy_clks = `SFRE_DC_SDR_01;
          2'b10: dummy_clks = `SFRE_DC_SDR_10;
          2'b11: dummy_clks = `SFRE_DC_SDR_11;
        endcase
      end
      RD_QDDR: begin
        unique case ({hi, lo})
          2'b00: dummy_clks = `SFRE_DC_DDR_00;
          2'b01: dummy_clks = `SFRE_DC_DDR_01;
          2'b10: dummy_clks = `SFRE_DC_DDR_10;
          2'b11: dummy_clks = `SFRE_DC_DDR_11;
        endcase
      end
    endcase
  endfunction

  // msb first, top group on the highest data line; one-bit data rides line 1
  function automatic sfre_pins_t place(input logic [7:0] b, input logic [3:0] wd);
    place = '0;
    if (wd == 4'd1) begin
      place.out = {2'b00, b[7], 1'b0};
      place.oe = 4'b0010;
    end else if (wd == 4'd2) begin
      place.out = {2'b00, b[7:6]};
      place.oe = 4'b0011;
    end else begin
      place.out = b[7:4];
      place.oe = 4'b1111;
    end
  endfunction

  // complementary nibbles enter or keep enhance mode
  function automatic logic ind_toggles(input logic [7:0] p);
    ind_toggles = p[7:4] == ~p[3:0];
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    byte_now = (s_r.bleft == 4'd0) ? fifo_out : s_r.sh;
    w = 4'd1;
    cnt_new = s_r.cnt;
    // preamble bit for this dummy slot sits in bit 0
    pre_w = `SFRE_PREAMBLE >> (4'd7 - (s_r.dcnt - `SFRE_IND_CLKS));
    s_nxt.sclk_s1 = link_sclk;
    s_nxt.sclk_s2 = s_r.sclk_s1;
    s_nxt.sclk_s3 = s_r.sclk_s2;
    s_nxt.cs_s1 = link_cs_n;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.io_s1 = io_line_in;
    s_nxt.io_s2 = s_r.io_s1;
    // array fetch runs ahead of the shifter
    if (arr_rd_en) begin
      s_nxt.pend = 1'b1;
      s_nxt.faddr = s_r.faddr + 1'b1;
    end else begin
      s_nxt.pend = 1'b0;
    end
    if (s_r.cs_s2) begin
      s_nxt.phase = PH_IDLE;
      s_nxt.pins = '0;
      s_nxt.fetch_on = 1'b0;
      s_nxt.pend = 1'b0;
    end else begin
      unique case (s_r.phase)
        PH_IDLE: begin
          s_nxt.cnt = '0;
          s_nxt.opc = '0;
          s_nxt.bleft = '0;
          if (s_r.enh) begin
            s_nxt.phase = PH_ADDR;
            s_nxt.cmd = s_r.enh_cmd;
          end else begin
            s_nxt.phase = PH_CMD;
          end
        end
        PH_CMD: begin
          if (rise) begin
            if (cfg.four_line_command_mode) begin
              s_nxt.opc = {s_r.opc[3:0], s_r.io_s2};
              cnt_new = s_r.cnt + 6'd4;
            end else begin
              s_nxt.opc = {s_r.opc[6:0], s_r.io_s2[0]};
              cnt_new = s_r.cnt + 6'd1;
            end
            s_nxt.cnt = cnt_new;
            if (cnt_new[3:0] == `SFRE_OPC_BITS) begin
              s_nxt.cnt = '0;
              s_nxt.phase = PH_ADDR;
              case (s_nxt.opc)
                `SFRE_OP_READ: s_nxt.cmd = RD_PLAIN;
                `SFRE_OP_FAST: s_nxt.cmd = RD_FAST;
                `SFRE_OP_DOUT: s_nxt.cmd = RD_DOUT;
                `SFRE_OP_DIO: s_nxt.cmd = RD_DIO;
                `SFRE_OP_QOUT: s_nxt.cmd = RD_QOUT;
                `SFRE_OP_QIO: s_nxt.cmd = RD_QIO;
                `SFRE_OP_QDDR: s_nxt.cmd = RD_QDDR;
                default: s_nxt.phase = PH_IGNORE;
              endcase
              // four-line mode only carries the quad io and ddr reads
              if (cfg.four_line_command_mode && s_nxt.cmd != RD_QIO && s_nxt.cmd != RD_QDDR) begin
                s_nxt.phase = PH_IGNORE;
              end
              if (write_busy && s_nxt.cmd != RD_PLAIN) begin
                s_nxt.phase = PH_IGNORE;
              end
            end
          end
        end
        PH_ADDR: begin
          // ddr address opens on a rise; the fall that ends the opcode clock is not an address edge
          if (rise || (fall && s_r.cmd == RD_QDDR && s_r.cnt != 6'd0)) begin
            w = addr_width(s_r.cmd);
            unique case (w)
              4'd1: s_nxt.addr = {s_r.addr[30:0], s_r.io_s2[0]};
              4'd2: s_nxt.addr = {s_r.addr[29:0], s_r.io_s2[1:0]};
              4'd4: s_nxt.addr = {s_r.addr[27:0], s_r.io_s2};
            endcase
            cnt_new = s_r.cnt + {2'b00, w};
            s_nxt.cnt = cnt_new;
            if (cnt_new == `SFRE_ADDR_BITS) begin
              s_nxt.faddr = s_nxt.addr[ARRAY_AW-1:0];
              s_nxt.fetch_on = 1'b1;
              s_nxt.dcnt = '0;
              s_nxt.dnum = dummy_clks(s_r.cmd, cfg.dummy_sel_hi, cfg.dummy_sel_lo);
              s_nxt.phase = (s_nxt.dnum == `SFRE_DUMMY_NONE) ? PH_DATA : PH_DUMMY;
            end
          end
        end
        PH_DUMMY: begin
          if (rise) begin
            s_nxt.dcnt = s_r.dcnt + 4'd1;
            s_nxt.pins = '0;
            if (s_r.cmd == RD_QIO && s_r.dcnt < `SFRE_IND_CLKS) begin
              s_nxt.ind = {s_r.ind[3:0], s_r.io_s2};
              if (s_r.dcnt == `SFRE_IND_CLKS - 4'd1) begin
                s_nxt.enh = ind_toggles(s_nxt.ind);
                s_nxt.enh_cmd = RD_QIO;
              end
            end
            if (s_r.cmd == RD_QDDR && s_r.dcnt == 4'd0) begin
              s_nxt.ind[7:4] = s_r.io_s2;
            end
            if (s_nxt.dcnt == s_r.dnum) begin
              s_nxt.phase = PH_DATA;
            end
          end else if (fall) begin
            if (s_r.cmd == RD_QDDR && s_r.dcnt == 4'd1) begin
              s_nxt.ind[3:0] = s_r.io_s2;
              s_nxt.enh = ind_toggles({s_r.ind[7:4], s_r.io_s2});
              s_nxt.enh_cmd = RD_QDDR;
            end
            // preamble slots start after the indicator clocks
            if (cfg.preamble_enable && s_r.dcnt >= `SFRE_IND_CLKS) begin
              s_nxt.pins = place({8{pre_w[0]}}, data_width(s_r.cmd));
            end else begin
              s_nxt.pins = '0;
            end
          end
        end
        PH_DATA: begin
          if (drive_ev) begin
            w = data_width(s_r.cmd);
            s_nxt.pins = place(byte_now, w);
            s_nxt.sh = byte_now << w;
            s_nxt.bleft = ((s_r.bleft == 4'd0) ? 4'd8 : s_r.bleft) - w;
          end
        end
        PH_IGNORE: begin
          s_nxt.pins = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.sclk_s1 <= 1'b0;
      s_r.cs_s1 <= 1'b1;
      s_r.cs_s2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // prefetch buffer
  // ************************************************************
  sfre_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .flush(s_r.cs_s2),
    .in_valid(s_r.pend),
    .in_ready(fifo_in_ready),
    .in_data(arr_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out)
  );
endmodule // sfre_serial_flash_read_engine
`default_nettype wire

/* tb/sfre_serial_flash_read_engine_asserts.sv */
`default_nettype none
module sfre_chk #(parameter int ARRAY_AW = 26) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire sfre_pkg::sfre_pins_t io_line_pins,
  input wire logic arr_rd_en,
  input wire logic [ARRAY_AW-1:0] arr_addr,
  input wire logic enhance_mode,
  input wire logic frame_active
);
  timeunit 1ns;
  timeprecision 1ps;
  import sfre_pkg::*;
  // ****
  // helpers and properties
  // ****
  logic sclk_d;
  logic prev_r;
  logic [3:0] age_r;
  logic [ARRAY_AW-1:0] last_r;
  // age_r counts cycles since the host clock last moved
  always_ff @(posedge sys_clk) begin
    sclk_d <= link_sclk;
    if (!reset_n || sclk_d != link_sclk) age_r <= 4'h0;
    else if (age_r != 4'hF) age_r <= age_r + 4'h1;
    if (!reset_n || link_cs_n) prev_r <= 1'b0;
    else if (arr_rd_en) prev_r <= 1'b1;
    if (arr_rd_en) last_r <= arr_addr;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence cs_idle;
    link_cs_n [*5];
  endsequence
  chk_cs_release: assert property (cs_idle |-> io_line_pins.oe == 4'h0)
    else $error("lines driven while deselected");
  chk_oe_shape: assert property (io_line_pins.oe inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hF})
    else $error("illegal line enable set");
  chk_drive_edge: assert property (($changed(io_line_pins.out) && io_line_pins.oe != 4'h0) |-> age_r < 4'h6)
    else $error("output moved without a clock edge");
  chk_addr_step: assert property ((arr_rd_en && prev_r) |-> arr_addr == last_r + 1'b1)
    else $error("array address did not advance by one");
  chk_reset_quiet: assert property ($rose(reset_n) |-> io_line_pins.oe == 4'h0 && !arr_rd_en && !enhance_mode)
    else $error("outputs active after reset");
  chk_enh_frame: assert property ($changed(enhance_mode) |-> $past(frame_active))
    else $error("enhance mode moved outside a frame");
  chk_idle_fetch: assert property (link_cs_n [*8] |-> !arr_rd_en)
    else $error("array fetch while deselected");
  chk_oe_frame: assert property (io_line_pins.oe != 4'h0 |-> frame_active)
    else $error("lines driven while idle");
endmodule // sfre_chk
`default_nettype wire

/* tb/sfre_host_model.sv */
`default_nettype none
module sfre_host_model (
  input wire logic sys_clk,
  input wire sfre_pkg::sfre_pins_t io_line_pins,
  output logic link_sclk,
  output logic link_cs_n,
  output logic [3:0] io_line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import sfre_pkg::*;
  // ****
  // host side of the link
  // ****
  logic [3:0] drv = 4'h0;
  logic [3:0] den = 4'h0;
  logic junk = 1'b0;
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
  end
  always @(posedge sys_clk) junk <= ~junk;
  // undriven lines show a moving pattern, never a stale level
  always_comb
    for (int i = 0; i < 4; i++)
      io_line_in[i] = io_line_pins.oe[i] ? io_line_pins.out[i] : den[i] ? drv[i] : junk ^ i[0];
  task automatic sel(input logic v);
    @(posedge sys_clk);
    #1 link_cs_n = v;
  endtask
  // one half period: set lines, move the clock, sample what was driven before
  task automatic hf(input logic [3:0] v, input logic [3:0] en, output logic [3:0] got);
    drv = v;
    den = en;
    repeat (2) @(posedge sys_clk);
    #1 link_sclk = ~link_sclk;
    repeat (2) @(posedge sys_clk);
    #1 got = io_line_in;
  endtask
endmodule // sfre_host_model
`default_nettype wire

/* tb/tb_sfre_serial_flash_read_engine.sv */
`include "sfre_cfg.svh"
`default_nettype none
module tb_sfre_serial_flash_read_engine;
  timeunit 1ns;
  timeprecision 1ps;
  import sfre_pkg::*;
  // ****
  // bench
  // ****
  localparam logic [7:0] PRE = `SFRE_PREAMBLE;
  localparam int DSDR [4] = '{`SFRE_DC_SDR_00, `SFRE_DC_SDR_01, `SFRE_DC_SDR_10, `SFRE_DC_SDR_11};
  localparam int DDDR [4] = '{`SFRE_DC_DDR_00, `SFRE_DC_DDR_01, `SFRE_DC_DDR_10, `SFRE_DC_DDR_11};
  localparam logic [7:0] REJ [5] = '{`SFRE_OP_FAST, `SFRE_OP_DOUT, `SFRE_OP_DIO, `SFRE_OP_QIO, `SFRE_OP_QDDR};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic write_busy = 1'b0;
  logic [7:0] arr_data = 8'h00;
  sfre_cfg_t cfg = '0;
  wire logic link_sclk;
  wire logic link_cs_n;
  wire logic [3:0] io_line_in;
  sfre_pins_t io_line_pins;
  wire logic arr_rd_en;
  wire logic [25:0] arr_addr;
  wire logic enhance_mode;
  wire logic frame_active;
  int errors = 0;
  int n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  sfre_serial_flash_read_engine sfre_serial_flash_read_engine_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .io_line_in(io_line_in), .io_line_pins(io_line_pins),
    .cfg(cfg), .write_busy(write_busy), .arr_rd_en(arr_rd_en), .arr_addr(arr_addr), .arr_data(arr_data),
    .enhance_mode(enhance_mode), .frame_active(frame_active));
  sfre_host_model sfre_host_model_i (.sys_clk(sys_clk), .io_line_pins(io_line_pins), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .io_line_in(io_line_in));
  function automatic logic [7:0] mem(input logic [25:0] a);
    return a[7:0] + {a[17:16], a[25:20]};
  endfunction
  function automatic logic [3:0] msk(input int w);
    return w == 1 ? 4'h1 : w == 2 ? 4'h3 : 4'hF;
  endfunction
  always @(posedge sys_clk) if (arr_rd_en) arr_data <= mem(arr_addr);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic clk1(input logic [3:0] v, input logic [3:0] en, output logic [3:0] got);
    logic [3:0] g;
    sfre_host_model_i.hf(v, en, got);
    sfre_host_model_i.hf(v, en, g);
  endtask
  task automatic send(input int w, input logic [31:0] v, input int n);
    logic [3:0] g;
    for (int i = n / w - 1; i >= 0; i--)
      clk1(4'(v >> (i * w)) & msk(w), msk(w), g);
  endtask
  // one read frame: opcode width 0 skips the opcode, address or data width 8 means double rate
  task automatic rd(input logic [7:0] op, input int ow, input int aw, input logic [31:0] a, input int nd,
                    input logic [7:0] ind, input int dw, input int nb, input bit ok);
    logic [3:0] g;
    logic [3:0] h;
    logic [7:0] b;
    int sh;
    sh = dw == 8 ? 4 : dw;
    sfre_host_model_i.sel(1'b0);
    if (ow > 0) send(ow, op, 8);
    if (aw == 8)
      for (int i = 7; i >= 0; i--) sfre_host_model_i.hf(4'(a >> (i * 4)), 4'hF, g);
    else
      send(aw, a, 32);
    for (int d = 0; d < nd; d++) begin
      if (aw == 8) begin
        sfre_host_model_i.hf(ind[7:4], d == 0 ? 4'hF : 4'h0, g);
        sfre_host_model_i.hf(ind[3:0], d == 0 ? 4'hF : 4'h0, g);
      end else begin
        clk1(d != 0 ? ind[3:0] : ind[7:4], (aw == 4 && d < 2) ? 4'hF : 4'h0, g);
        if (d > 1 && ok) begin
          if (!cfg.preamble_enable) chk(io_line_pins.oe, 32'h0);
          else if (aw == 4) chk(g, {28'h0, {4{PRE[9 - d]}}});
        end
      end
    end
    for (int k = 0; k < nb; k++) begin
      for (int j = 0; j < 8 / sh; j++) begin
        if (dw == 8) sfre_host_model_i.hf(4'h0, 4'h0, g);
        else clk1(4'h0, 4'h0, g);
        h = dw == 1 ? {3'b000, g[1]} : g & msk(dw);
        b = (b << sh) | 8'(h);
      end
      if (ok) chk(b, mem(26'(a + k)));
      else chk(io_line_pins.oe, 32'h0);
    end
    chk(io_line_pins.oe, ok ? (dw == 1 ? 32'h2 : 32'(msk(dw))) : 32'h0);
    sfre_host_model_i.sel(1'b1);
    repeat (6) @(posedge sys_clk);
    chk(io_line_pins.oe, 32'h0);
    #1;
  endtask
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    rd(`SFRE_OP_READ, 1, 1, 32'h03FF_FFFE, 0, 8'h00, 1, 3, 1);
    rd(`SFRE_OP_FAST, 1, 1, 32'h0001_2345, 10, 8'h00, 1, 2, 1);
    rd(`SFRE_OP_DOUT, 1, 1, 32'h0012_3456, 10, 8'h00, 2, 2, 1);
    rd(`SFRE_OP_DIO, 1, 2, 32'h0123_4567, 10, 8'h00, 2, 2, 1);
    write_busy = 1'b1;
    rd(`SFRE_OP_QOUT, 1, 1, 32'h0000_0100, 10, 8'h00, 4, 1, 0);
    foreach (REJ[i]) rd(REJ[i], 1, 1, 32'h0000_0100, 10, 8'h00, 4, 1, 0);
    rd(`SFRE_OP_READ, 1, 1, 32'h0000_0200, 0, 8'h00, 1, 1, 1);
    write_busy = 1'b0;
    rd(`SFRE_OP_QOUT, 1, 1, 32'h0234_5678, 10, 8'h00, 4, 2, 1);
    for (int s = 0; s < 4; s++) begin
      {cfg.dummy_sel_hi, cfg.dummy_sel_lo} = 2'(s);
      cfg.preamble_enable = s != 0;
      rd(`SFRE_OP_QIO, 1, 4, 32'h0100_0000 + s, DSDR[s], 8'hFF, 4, 2, 1);
    end
    cfg.four_line_command_mode = 1'b1;
    rd(`SFRE_OP_QIO, 4, 4, 32'h0000_0ABC, DSDR[3], 8'h00, 4, 2, 1);
    rd(`SFRE_OP_QIO, 4, 4, 32'h0000_1000, DSDR[3], 8'hA5, 4, 2, 1);
    chk(enhance_mode, 32'h1);
    rd(8'h00, 0, 4, 32'h0000_2000, DSDR[3], 8'h5A, 4, 2, 1);
    chk(enhance_mode, 32'h1);
    rd(8'h00, 0, 4, 32'h0000_3000, DSDR[3], 8'hFF, 4, 1, 1);
    chk(enhance_mode, 32'h0);
    cfg = '0;
    rd(`SFRE_OP_QDDR, 1, 8, 32'h0345_6789, DDDR[0], 8'h00, 8, 2, 1);
    cfg = 4'b1001;
    rd(`SFRE_OP_QDDR, 4, 8, 32'h0000_4000, DDDR[2], 8'h5A, 8, 2, 1);
    chk(enhance_mode, 32'h1);
    rd(8'h00, 0, 8, 32'h0000_5000, DDDR[2], 8'hFF, 8, 1, 1);
    chk(enhance_mode, 32'h0);
    wrap_up();
  end
endmodule // tb_sfre_serial_flash_read_engine
bind sfre_serial_flash_read_engine sfre_chk #(.ARRAY_AW(ARRAY_AW)) sfre_chk_i (.sys_clk(sys_clk),
  .reset_n(reset_n), .link_sclk(link_sclk), .link_cs_n(link_cs_n), .io_line_pins(io_line_pins),
  .arr_rd_en(arr_rd_en), .arr_addr(arr_addr), .enhance_mode(enhance_mode), .frame_active(frame_active));
`default_nettype wire
